// >>> hdl/lcc_pkg.sv
// lcc_pkg: constants and types for line channel control register 0
// assumes: one 50 MHz clock, AXI4-Lite register access
package lcc_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] LCC0_OFFSET = 16'h0f00;
    localparam logic [7:0] LCC0_RESET = 8'h00;
    localparam int PAT_TYPE_BIT = 7;
    localparam int PAT_ROUTE_BIT = 6;
    localparam int RX_ON_BIT = 5;
    localparam int PROFILE_MSB = 4;
    localparam logic [4:0] PROFILE_RESET = 5'h00;
    localparam logic [4:0] ARB_T1_SHORT = 5'h0d;
    localparam logic [4:0] ARB_T1_GAIN = 5'h13;
    localparam logic [15:0] ARB_SEG_FIRST = 16'h0f08;
    localparam logic [15:0] ARB_SEG_LAST = 16'h0f0f;
    localparam int PRBS_LEN_LOG2 = 15;
    localparam int QRSS_LEN_LOG2 = 20;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    // line haul class
    typedef enum logic [1:0] {
        HAUL_LONG = 2'h0,
        HAUL_SHORT = 2'h1,
        HAUL_GAIN = 2'h2
    } lcc_haul_t;

    // receive sensitivity
    typedef enum logic [1:0] {
        SENS_15DB = 2'h0,
        SENS_29DB = 2'h1,
        SENS_36DB = 2'h2,
        SENS_45DB = 2'h3
    } lcc_sens_t;

    // transmit pulse shape kind
    typedef enum logic [1:0] {
        PULSE_LBO = 2'h0,
        PULSE_CABLE = 2'h1,
        PULSE_ARB = 2'h2,
        PULSE_E1STD = 2'h3
    } lcc_pulse_t;

    // cable kind
    typedef enum logic [1:0] {
        CABLE_TP100 = 2'h0,
        CABLE_COAX75 = 2'h1,
        CABLE_TP120 = 2'h2
    } lcc_cable_t;
endpackage

// >>> hdl/lcc_axil_slave.sv
// lcc_axil_slave: AXI4-Lite slave for one 8-bit register
// assumes: one write and one read outstanding at a time
`timescale 1ns/1ns
module lcc_axil_slave
    import lcc_pkg::*;
#(
    parameter logic [15:0] REG_ADDR = 16'h0f00
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic regWrite,
    output logic [7:0] regWdata,
    input wire logic [7:0] regValue
);
    logic awHeld_q;
    logic [15:0] awAddr_q;
    logic wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bValid_q;
    logic [1:0] bResp_q;
    logic rValid_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;

    wire doWrite = awHeld_q && wHeld_q && !bValid_q;
    wire wrHit = awAddr_q[15:2] == REG_ADDR[15:2];
    wire rdHit = s_axi_araddr[15:2] == REG_ADDR[15:2];
    wire rdTake = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign regWrite = doWrite && wrHit && wStrb_q[0];
    assign regWdata = wData_q[7:0];

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b0;
            rValid_q <= 1'b0;
            awAddr_q <= 16'h0000;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bResp_q <= AXI_OKAY;
            rData_q <= 32'h00000000;
            rResp_q <= AXI_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wrHit ? AXI_OKAY : AXI_SLVERR;
            end
            else if (bValid_q && s_axi_bready)
                bValid_q <= 1'b0;
            if (rdTake)
            begin
                rValid_q <= 1'b1;
                rData_q <= rdHit ? {24'h000000, regValue} : 32'h00000000;
                rResp_q <= rdHit ? AXI_OKAY : AXI_SLVERR;
            end
            else if (rValid_q && s_axi_rready)
                rValid_q <= 1'b0;
        end
    end
endmodule // lcc_axil_slave

// >>> hdl/lcc_profile_decode.sv
// lcc_profile_decode: five-bit profile code to line settings
// assumes: code comes from a register on the same clock
`timescale 1ns/1ns
module lcc_profile_decode
    import lcc_pkg::*;
(
    input wire logic [4:0] profileCode,
    output logic isE1,
    output lcc_haul_t haul,
    output lcc_sens_t sens,
    output lcc_pulse_t pulse,
    output lcc_cable_t cable,
    output logic [2:0] shapeSel
);
    wire t1Long = profileCode <= 5'h07;
    wire t1Short = profileCode >= 5'h08 && profileCode <= ARB_T1_SHORT;
    wire t1Gain = profileCode >= 5'h0e && profileCode <= 5'h17;
    wire [4:0] gainIdx = profileCode - 5'h0e;
    wire [1:0] e1Class = profileCode[2:1];
    wire arbCode = profileCode == ARB_T1_SHORT || profileCode == ARB_T1_GAIN;

    assign isE1 = profileCode[4] && profileCode[3];
    assign haul = isE1 ? (e1Class[1] ? (e1Class[0] ? HAUL_GAIN : HAUL_SHORT) : HAUL_LONG)
        : t1Long ? HAUL_LONG : t1Short ? HAUL_SHORT : HAUL_GAIN;
    assign sens = isE1 ? (e1Class == 2'h0 ? SENS_36DB : e1Class == 2'h1 ? SENS_45DB
        : e1Class == 2'h2 ? SENS_15DB : SENS_29DB)
        : t1Long ? (profileCode[2] ? SENS_45DB : SENS_36DB)
        : t1Short ? SENS_15DB : SENS_29DB;
    assign pulse = isE1 ? PULSE_E1STD
        : arbCode ? PULSE_ARB
        : t1Long ? PULSE_LBO
        : t1Short ? PULSE_CABLE
        : (t1Gain && gainIdx <= 5'h04) ? PULSE_CABLE : PULSE_LBO;
    assign cable = !isE1 ? CABLE_TP100 : profileCode[0] ? CABLE_TP120 : CABLE_COAX75;
    // build-out step 0..3 or cable band 0..4, zero for E1 and arbitrary
    assign shapeSel = (isE1 || arbCode) ? 3'h0
        : t1Long ? {1'b0, profileCode[1:0]}
        : t1Short ? 3'(profileCode - 5'h08)
        : gainIdx <= 5'h04 ? gainIdx[2:0]
        : 3'(profileCode - 5'h14);
endmodule // lcc_profile_decode

// >>> hdl/lcc_control_reg.sv
// lcc_control_reg: line channel control register 0 with decoded controls
// assumes: software on AXI4-Lite, one clock sys_clk at 50 MHz
// How it works
// - bit 7 picks pattern: 0 gives 2^15-1 sequence, 1 gives 2^20-1
// - bit 6 routes enabled generator to transmit line or receive data/clock
// - bit 5 one turns receive section on, zero shuts it off
// - receive off powers down receive logic but master clock loop runs
// - bits 4..0 hold profile code, reset zero, selecting shaping and sensitivity
// - codes 0x0d and 0x13 use eight arbitrary segment registers 0x0f08-0x0f0f
// - codes 0x00-0x07 T1 long haul, 36 or 45 dB, four build-outs
// - codes 0x08-0x0c T1 short haul 15 dB, five cable bands
// - codes 0x0e-0x17 T1 gain 29 dB: bands, arbitrary, build-outs
// - codes 0x18-0x1f E1: bit 0 cable, bits 2:1 haul and sensitivity
`timescale 1ns/1ns
module lcc_control_reg
    import lcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic patternEnable,
    input wire logic patternData,
    input wire logic patternClock,
    input wire logic lineTxData,
    input wire logic rxRecoveredData,
    input wire logic rxRecoveredClock,
    output logic patternType,
    output logic tx_line_tip,
    output logic tx_line_ring,
    output logic rx_positive_data,
    output logic rx_clock_out,
    output logic rxSectionEnable,
    output logic rxPowerDown,
    output logic masterClockPllEnable,
    output logic isE1,
    output lcc_pkg::lcc_haul_t haul,
    output lcc_pkg::lcc_sens_t sens,
    output lcc_pkg::lcc_pulse_t pulse,
    output lcc_pkg::lcc_cable_t cable,
    output logic [2:0] shapeSel,
    output logic arbSegmentsActive,
    output logic [15:0] arbSegFirstAddr,
    output logic [15:0] arbSegLastAddr
);
    import lcc_pkg::*;

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic regWrite;
    logic [7:0] regWdata;
    logic patternType_q;
    logic patternRoute_q;
    logic rxOn_q;
    logic [4:0] profile_q;
    logic txTip_q;
    logic txRing_q;
    logic rxPos_q;
    logic rxClk_q;
    logic isE1W;
    lcc_haul_t haulW;
    lcc_sens_t sensW;
    lcc_pulse_t pulseW;
    lcc_cable_t cableW;
    logic [2:0] shapeW;

    lcc_axil_slave #(
        .REG_ADDR(LCC0_OFFSET)
    ) u_bus (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regWrite(regWrite),
        .regWdata(regWdata),
        .regValue(ctrl_q)
    );

    assign ctrl_d = regWrite ? regWdata : ctrl_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            ctrl_q <= LCC0_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    // decoded copies settle one cycle after ctrl_q, two cycles after regWrite
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            patternType_q <= 1'b0;
            patternRoute_q <= 1'b0;
            rxOn_q <= 1'b0;
            profile_q <= PROFILE_RESET;
        end
        else
        begin
            patternType_q <= ctrl_q[PAT_TYPE_BIT];
            patternRoute_q <= ctrl_q[PAT_ROUTE_BIT];
            rxOn_q <= ctrl_q[RX_ON_BIT];
            profile_q <= ctrl_q[PROFILE_MSB:0];
        end
    end

    lcc_profile_decode u_dec (
        .profileCode(profile_q),
        .isE1(isE1W),
        .haul(haulW),
        .sens(sensW),
        .pulse(pulseW),
        .cable(cableW),
        .shapeSel(shapeW)
    );

    assign isE1 = isE1W;
    assign haul = haulW;
    assign sens = sensW;
    assign pulse = pulseW;
    assign cable = cableW;
    assign shapeSel = shapeW;

    assign arbSegmentsActive = pulseW == PULSE_ARB;
    assign arbSegFirstAddr = ARB_SEG_FIRST;
    assign arbSegLastAddr = ARB_SEG_LAST;

    assign patternType = patternType_q;

    assign rxSectionEnable = rxOn_q;
    assign rxPowerDown = !rxOn_q;
    assign masterClockPllEnable = 1'b1;

    wire genTx = patternEnable && !patternRoute_q;
    wire genRx = patternEnable && patternRoute_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            txTip_q <= 1'b0;
            txRing_q <= 1'b0;
            rxPos_q <= 1'b0;
            rxClk_q <= 1'b0;
        end
        else
        begin
            txTip_q <= genTx ? patternData : lineTxData;
            txRing_q <= genTx ? !patternData : !lineTxData;
            rxPos_q <= genRx ? patternData : (rxOn_q && rxRecoveredData);
            rxClk_q <= genRx ? patternClock : (rxOn_q && rxRecoveredClock);
        end
    end

    assign tx_line_tip = txTip_q;
    assign tx_line_ring = txRing_q;
    assign rx_positive_data = rxPos_q;
    assign rx_clock_out = rxClk_q;

    property p_write_lands;
        @(posedge sys_clk) disable iff (!rstn)
        regWrite |=> ctrl_q == $past(regWdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("register lost write");

    property p_read_value;
        @(posedge sys_clk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == LCC0_OFFSET && !regWrite
            |=> s_axi_rvalid && s_axi_rdata[7:0] == ctrl_q && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_read_value: assert property (p_read_value) else $error("read value wrong");

    property p_pattern_type;
        @(posedge sys_clk) disable iff (!rstn)
        regWrite ##1 1'b1 |=> patternType == $past(regWdata[PAT_TYPE_BIT], 2);
    endproperty
    a_pattern_type: assert property (p_pattern_type) else $error("pattern type wrong");

    property p_route_tx;
        @(posedge sys_clk) disable iff (!rstn)
        patternEnable && !patternRoute_q |=> tx_line_tip == $past(patternData);
    endproperty
    a_route_tx: assert property (p_route_tx) else $error("tx route wrong");

    property p_route_rx;
        @(posedge sys_clk) disable iff (!rstn)
        patternEnable && patternRoute_q |=> rx_positive_data == $past(patternData)
            && rx_clock_out == $past(patternClock);
    endproperty
    a_route_rx: assert property (p_route_rx) else $error("rx route wrong");

    property p_rx_on;
        @(posedge sys_clk) disable iff (!rstn)
        regWrite && regWdata[RX_ON_BIT] ##1 !regWrite |=> rxSectionEnable && !rxPowerDown;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receive on wrong");

    property p_rx_off_pll;
        @(posedge sys_clk) disable iff (!rstn)
        !rxSectionEnable |-> rxPowerDown && masterClockPllEnable
            && ($past(rxSectionEnable) || $past(genRx) || (!rx_positive_data && !rx_clock_out));
    endproperty
    a_rx_off_pll: assert property (p_rx_off_pll) else $error("power down wrong");

    property p_arb;
        @(posedge sys_clk) disable iff (!rstn)
        arbSegmentsActive == (profile_q == ARB_T1_SHORT || profile_q == ARB_T1_GAIN);
    endproperty
    a_arb: assert property (p_arb) else $error("arbitrary select wrong");

    property p_long;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q <= 5'h07 |-> haul == HAUL_LONG && sens == (profile_q[2] ? SENS_45DB : SENS_36DB)
            && shapeSel == {1'b0, profile_q[1:0]};
    endproperty
    a_long: assert property (p_long) else $error("long haul decode wrong");

    property p_short;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h08 && profile_q <= 5'h0c |-> haul == HAUL_SHORT && sens == SENS_15DB
            && pulse == PULSE_CABLE;
    endproperty
    a_short: assert property (p_short) else $error("short haul decode wrong");

    property p_gain;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h14 && profile_q <= 5'h17 |-> haul == HAUL_GAIN && sens == SENS_29DB
            && pulse == PULSE_LBO && shapeSel == {1'b0, profile_q[1:0]};
    endproperty
    a_gain: assert property (p_gain) else $error("gain decode wrong");

    property p_e1;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h18 |-> isE1 && pulse == PULSE_E1STD
            && cable == (profile_q[0] ? CABLE_TP120 : CABLE_COAX75);
    endproperty
    a_e1: assert property (p_e1) else $error("e1 decode wrong");

    property p_reset;
        @(posedge sys_clk)
        !rstn |=> ctrl_q == LCC0_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");

    property p_profile_reset;
        @(posedge sys_clk)
        !rstn |=> profile_q == PROFILE_RESET && !rxSectionEnable && !patternType;
    endproperty
    a_profile_reset: assert property (p_profile_reset) else $error("controls not cleared");

    property p_ring_inverse;
        @(posedge sys_clk) disable iff (!rstn)
        $past(rstn) |-> tx_line_ring == !tx_line_tip;
    endproperty
    a_ring_inverse: assert property (p_ring_inverse) else $error("ring not inverse of tip");

    property p_tx_normal;
        @(posedge sys_clk) disable iff (!rstn)
        !(patternEnable && !patternRoute_q) |=> tx_line_tip == $past(lineTxData);
    endproperty
    a_tx_normal: assert property (p_tx_normal) else $error("tx normal data wrong");

    property p_rx_normal;
        @(posedge sys_clk) disable iff (!rstn)
        !(patternEnable && patternRoute_q) && rxSectionEnable |=> rx_positive_data == $past(rxRecoveredData)
            && rx_clock_out == $past(rxRecoveredClock);
    endproperty
    a_rx_normal: assert property (p_rx_normal) else $error("rx normal data wrong");

    property p_rx_off;
        @(posedge sys_clk) disable iff (!rstn)
        regWrite && !regWdata[RX_ON_BIT] ##1 !regWrite |=> !rxSectionEnable && rxPowerDown;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receive off wrong");

    property p_short_band;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h08 && profile_q <= 5'h0c |-> shapeSel == profile_q[2:0] && !arbSegmentsActive;
    endproperty
    a_short_band: assert property (p_short_band) else $error("short haul band wrong");

    property p_gain_band;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h0e && profile_q <= 5'h12 |-> haul == HAUL_GAIN && sens == SENS_29DB
            && pulse == PULSE_CABLE && shapeSel == 3'(profile_q - 5'h0e);
    endproperty
    a_gain_band: assert property (p_gain_band) else $error("gain band wrong");

    property p_arb_shape;
        @(posedge sys_clk) disable iff (!rstn)
        arbSegmentsActive |-> pulse == PULSE_ARB && shapeSel == 3'h0 && arbSegFirstAddr == ARB_SEG_FIRST
            && arbSegLastAddr == ARB_SEG_LAST;
    endproperty
    a_arb_shape: assert property (p_arb_shape) else $error("arbitrary shape wrong");

    property p_e1_class;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q >= 5'h18 |-> shapeSel == 3'h0
            && haul == (profile_q[2] ? (profile_q[1] ? HAUL_GAIN : HAUL_SHORT) : HAUL_LONG)
            && sens == (profile_q[2:1] == 2'h0 ? SENS_36DB : profile_q[2:1] == 2'h1 ? SENS_45DB
            : profile_q[2:1] == 2'h2 ? SENS_15DB : SENS_29DB);
    endproperty
    a_e1_class: assert property (p_e1_class) else $error("e1 class wrong");

    property p_t1_cable;
        @(posedge sys_clk) disable iff (!rstn)
        profile_q < 5'h18 |-> !isE1 && cable == CABLE_TP100;
    endproperty
    a_t1_cable: assert property (p_t1_cable) else $error("t1 cable wrong");

    property p_write_ok;
        @(posedge sys_clk) disable iff (!rstn)
        regWrite |=> s_axi_bvalid && s_axi_bresp == AXI_OKAY;
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("write response wrong");
endmodule // lcc_control_reg

// >>> verif/test_line_interface_control_reg0.sv
// test_line_interface_control_reg0: self-checking bench for the channel control register
// assumes: lcc_pkg and lcc_control_reg compiled first; bench drives every port itself
`timescale 1ns/1ns
module test_line_interface_control_reg0;
    import lcc_pkg::*;

    logic sysClk;
    logic rstn;
    logic [15:0] awAddr;
    logic [15:0] arAddr;
    logic awValid, wValid, bReady, arValid, rReady;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic patEn, patData, patClk, txData, rxData, rxClk;
    logic patType, tip, ring, rxPos, rxClkOut, rxEn, rxPd, pllEn, isE1, arbAct;
    lcc_haul_t haul;
    lcc_sens_t sens;
    lcc_pulse_t pulse;
    lcc_cable_t cable;
    logic [2:0] shapeSel;
    logic [15:0] segFirst;
    logic [15:0] segLast;
    int miscompares;
    int testsRun;
    logic [7:0] model;

    lcc_control_reg i_dut (
        .sys_clk(sysClk), .rstn(rstn),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .patternEnable(patEn), .patternData(patData), .patternClock(patClk),
        .lineTxData(txData), .rxRecoveredData(rxData), .rxRecoveredClock(rxClk),
        .patternType(patType), .tx_line_tip(tip), .tx_line_ring(ring),
        .rx_positive_data(rxPos), .rx_clock_out(rxClkOut),
        .rxSectionEnable(rxEn), .rxPowerDown(rxPd), .masterClockPllEnable(pllEn),
        .isE1(isE1), .haul(haul), .sens(sens), .pulse(pulse), .cable(cable), .shapeSel(shapeSel),
        .arbSegmentsActive(arbAct), .arbSegFirstAddr(segFirst), .arbSegLastAddr(segLast)
    );

    initial
    begin
        sysClk = 1'b0;
        forever #10 sysClk = ~sysClk;
    end

    task automatic testDone();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timedOut(input bit done);
        if (!done)
        begin
            miscompares++;
            $display("BAD handshake wait ran out");
            testDone();
        end
    endtask

    task automatic axiWrite(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        bit done;
        r = 2'b11;
        done = 0;
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (int n = 0; n < 200 && !done; n++)
        begin
            @(posedge sysClk);
            if (awValid && awReady)
                awValid <= 1'b0;
            if (wValid && wReady)
                wValid <= 1'b0;
            if (bValid)
            begin
                r = bResp;
                bReady <= 1'b0;
                done = 1;
            end
        end
        timedOut(done);
    endtask

    task automatic axiRead(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (int n = 0; n < 200 && !done; n++)
        begin
            @(posedge sysClk);
            if (arValid && arReady)
                arValid <= 1'b0;
            if (rValid)
            begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                done = 1;
            end
        end
        timedOut(done);
    endtask

    // expected {isE1, haul, sens, pulse, cable, shapeSel} for a profile code
    function automatic logic [11:0] expDecode(input logic [4:0] c);
        logic [1:0] h, s, p, cb;
        logic [2:0] sh;
        cb = CABLE_TP100;
        sh = 3'h0;
        p = PULSE_LBO;
        if (c < 5'h08)
        begin
            h = HAUL_LONG;
            s = c[2] ? SENS_45DB : SENS_36DB;
            sh = {1'b0, c[1:0]};
        end
        else if (c < 5'h0e)
        begin
            h = HAUL_SHORT;
            s = SENS_15DB;
            p = (c == 5'h0d) ? PULSE_ARB : PULSE_CABLE;
            sh = (c == 5'h0d) ? 3'h0 : 3'(c - 5'h08);
        end
        else if (c < 5'h18)
        begin
            h = HAUL_GAIN;
            s = SENS_29DB;
            p = (c == 5'h13) ? PULSE_ARB : (c < 5'h13) ? PULSE_CABLE : PULSE_LBO;
            sh = (c == 5'h13) ? 3'h0 : (c < 5'h13) ? 3'(c - 5'h0e) : 3'(c - 5'h14);
        end
        else
        begin
            p = PULSE_E1STD;
            cb = c[0] ? CABLE_TP120 : CABLE_COAX75;
            h = (c[2:1] == 2'h2) ? HAUL_SHORT : (c[2:1] == 2'h3) ? HAUL_GAIN : HAUL_LONG;
            s = (c[2:1] == 2'h0) ? SENS_36DB : (c[2:1] == 2'h1) ? SENS_45DB
                : (c[2:1] == 2'h2) ? SENS_15DB : SENS_29DB;
        end
        return {c >= 5'h18, h, s, p, cb, sh};
    endfunction

    task automatic checkAll();
        logic [31:0] d;
        logic [1:0] r;
        axiRead(LCC0_OFFSET, d, r);
        check("rresp", r, AXI_OKAY);
        check("rdata", d, {24'h0, model});
        check("patternType", patType, model[PAT_TYPE_BIT]);
        check("rxControl", {rxEn, rxPd, pllEn}, {model[RX_ON_BIT], !model[RX_ON_BIT], 1'b1});
        check("decode", {isE1, haul, sens, pulse, cable, shapeSel}, expDecode(model[4:0]));
        check("arbitrary", {arbAct, segFirst, segLast}, {model[4:0] == ARB_T1_SHORT || model[4:0] == ARB_T1_GAIN,
            ARB_SEG_FIRST, ARB_SEG_LAST});
    endtask

    task automatic checkPins();
        logic te;
        logic [1:0] rp;
        repeat (4)
        begin
            {patEn, patData, patClk, txData, rxData, rxClk} <= 6'($urandom);
            repeat (3) @(posedge sysClk);
            te = (patEn && !model[PAT_ROUTE_BIT]) ? patData : txData;
            rp = (patEn && model[PAT_ROUTE_BIT]) ? {patData, patClk} : model[RX_ON_BIT] ? {rxData, rxClk} : 2'b00;
            check("txLine", {tip, ring}, {te, !te});
            check("rxOutputs", {rxPos, rxClkOut}, rp);
        end
    endtask

    initial
    begin
        logic [7:0] v;
        logic [31:0] d;
        logic [1:0] r;
        rstn = 1'b0;
        {awAddr, arAddr, wData, wStrb} = '0;
        {awValid, wValid, bReady, arValid, rReady} = '0;
        {patEn, patData, patClk, txData, rxData, rxClk} = '0;
        miscompares = 0;
        testsRun = 0;
        model = LCC0_RESET;
        void'($urandom(45202));
        repeat (16) @(posedge sysClk);
        rstn <= 1'b1;
        @(posedge sysClk);
        checkAll();
        for (int c = 0; c < 32; c++)
        begin
            v = {3'($urandom), 5'(c)};
            axiWrite(LCC0_OFFSET, {24'($urandom), v}, 4'hf, r);
            check("bresp", r, AXI_OKAY);
            model = v;
            checkAll();
            checkPins();
        end
        // unmapped word is refused and leaves the register alone
        axiWrite(16'h0f04, 32'h0000_00a5, 4'hf, r);
        check("bresp unmapped", r, AXI_SLVERR);
        axiRead(16'h0f04, d, r);
        check("rresp unmapped", r, AXI_SLVERR);
        check("rdata unmapped", d, 32'h0);
        axiWrite(LCC0_OFFSET, 32'h0000_005a, 4'he, r);
        check("bresp no strobe", r, AXI_OKAY);
        checkAll();
        rstn <= 1'b0;
        repeat (2) @(posedge sysClk);
        rstn <= 1'b1;
        @(posedge sysClk);
        model = LCC0_RESET;
        checkAll();
        checkPins();
        testDone();
    end
endmodule // test_line_interface_control_reg0
